/* rtl/sdm_pkg.sv */
package sdm_pkg;
    // ----------------------------------------
    // word and switch layout
    // ----------------------------------------
    localparam int SDM_WORD_W = 8;            // serial control word width
    localparam int SDM_GRP_W = 4;             // switches per group
    localparam int SDM_B_MSB = 7;             // b group: bits 7..4, input 0 first
    localparam int SDM_A_MSB = 3;             // a group: bits 3..0, input 3 first
    localparam logic [7:0] SDM_WORD_RST = 8'h00;  // cleared word
    localparam logic [3:0] SDM_GRP_RST = 4'h0;    // all switches open
    // ----------------------------------------
    // controller timing
    // ----------------------------------------
    localparam int SDM_SCLK_DIV = 4;          // system clocks per link clock half period
    localparam logic [2:0] SDM_CNT_LAST = 3'h7;  // last bit index of a word
    // ----------------------------------------
    // controller register map
    // ----------------------------------------
    localparam logic [3:0] SDM_REG_TXWORD = 4'h0;  // write: word to send, starts a frame
    localparam logic [3:0] SDM_REG_STATUS = 4'h4;  // read: bit0 busy
    localparam logic [3:0] SDM_REG_RXWORD = 4'h8;  // read: word shifted back from dout
    localparam logic [3:0] SDM_REG_CTRL = 4'hC;    // bit0 drives device reset low when 1

    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [3:0]
    {
        SDM_IDLE = 4'h1,
        SDM_LOW = 4'h2,
        SDM_HIGH = 4'h4,
        SDM_DONE = 4'h8
    } sdm_state_t;

    // b input n sits at word bit 7-n; returns group b as input index order
    function automatic logic [3:0] sdm_group_b(input logic [7:0] w);
        sdm_group_b = {w[SDM_B_MSB-3], w[SDM_B_MSB-2], w[SDM_B_MSB-1], w[SDM_B_MSB]};
    endfunction

    // a input n sits at word bit n
    function automatic logic [3:0] sdm_group_a(input logic [7:0] w);
        sdm_group_a = w[SDM_A_MSB:0];
    endfunction
endpackage

/* rtl/sdm_link_if.sv */
// four wire serial link plus the device reset line
interface sdm_link_if;
    logic sclk;       // link clock, made by the controller
    logic cs_n;       // select, active low
    logic din;        // controller to device data
    logic dout;       // device to controller data
    logic reset_n;    // device reset, active low

    modport ctrl
    (
        output sclk,
        output cs_n,
        output din,
        output reset_n,
        input dout
    );

    modport dev
    (
        input sclk,
        input cs_n,
        input din,
        input reset_n,
        output dout
    );
endinterface

/* rtl/sdm_device.sv */
// Operation
// - reset low: switches open, register zero
// - bits 7..4 drive b inputs 0..3
// - bits 3..0 drive a inputs 3..0
// - msb first, shifted msb first
// - reset acts at once, no clock
// - reset high: normal operation, dout driven
// - shift on rising clock while selected
// - dout on falling edge, eight late
// - latch last eight bits on select rise
module sdm_device
    import sdm_pkg::*;
#(
    parameter int WORD_W = SDM_WORD_W
)
(
    sdm_link_if.dev link,
    output logic [3:0] group_a_input_o,   // 1 = input n closed to group_a_common
    output logic [3:0] group_b_input_o    // 1 = input n closed to group_b_common
);
    // ----------------------------------------
    // shift register on the link clock
    // ----------------------------------------
    logic [WORD_W-1:0] shift_ff;      // serial word, msb entered first
    logic dout_ff;                    // falling edge copy of the msb
    logic [WORD_W-1:0] latch_ff;      // switch latch
    wire [WORD_W-1:0] nxt_shift = {shift_ff[WORD_W-2:0], link.din};

    // shift only while selected; the reset pin clears at once
    always_ff @(posedge link.sclk or negedge link.reset_n)
    begin
        if (!link.reset_n)
            shift_ff <= SDM_WORD_RST;
        else if (!link.cs_n)
            shift_ff <= nxt_shift;
    end

    // dout changes on falling edge; while deselected it keeps the msb (first bit)
    always_ff @(negedge link.sclk or negedge link.reset_n)
    begin
        if (!link.reset_n)
            dout_ff <= 1'b0;
        else
            dout_ff <= shift_ff[WORD_W-1];
    end

    // switches hold while shifting; load on rising select edge, any clock state
    always_ff @(posedge link.cs_n or negedge link.reset_n)
    begin
        if (!link.reset_n)
            latch_ff <= SDM_WORD_RST;
        else
            latch_ff <= shift_ff;
    end

    assign link.dout = dout_ff;
    assign group_b_input_o = sdm_group_b(latch_ff);
    assign group_a_input_o = sdm_group_a(latch_ff);
endmodule

/* rtl/sdm_ctrl.sv */
// controller end: shifts a word out msb first and reads the returning stream
//
// Implementation choices: the plain strobed port and the register offsets.
module sdm_ctrl
    import sdm_pkg::*;
#(
    parameter int DIV = SDM_SCLK_DIV
)
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    sdm_link_if.ctrl link
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    sdm_state_t state_ff;
    logic [7:0] tx_ff;              // word being sent
    logic [7:0] rx_ff;              // word returned on dout
    logic [2:0] bit_ff;             // bits left minus one
    logic [7:0] div_ff;             // half period counter
    logic sclk_ff, cs_n_ff, rst_ctl_ff;
    logic [7:0] rdata_ff;
    logic [2:0] dout_sync_ff;       // pin synchroniser
    logic dout_held_ff;             // last level on which stages 2 and 3 agreed
    logic dev_rst_n_ff;             // device reset line, low through controller reset
    // a half-settled pin keeps the last agreed level
    wire dout_s = (dout_sync_ff[2] == dout_sync_ff[1]) ? dout_sync_ff[2] : dout_held_ff;
    // ctrl write takes effect in the same edge as the register
    wire nxt_rst_ctl = (wr_i && addr_i == SDM_REG_CTRL) ? wdata_i[0] : rst_ctl_ff;
    wire half_done = (div_ff == 8'(DIV - 1));
    wire start = wr_i && (addr_i == SDM_REG_TXWORD) && (state_ff == SDM_IDLE);

    // dout sampled through three flops; use only when stages 2 and 3 agree
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dout_sync_ff <= 3'h0;
            dout_held_ff <= 1'b0;
        end
        else
        begin
            dout_sync_ff <= {dout_sync_ff[1:0], link.dout};
            dout_held_ff <= dout_s;
        end
    end

    // ----------------------------------------
    // frame engine: cpol 0, data set while clock low
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_ff <= SDM_IDLE;
            tx_ff <= 8'h00;
            rx_ff <= 8'h00;
            bit_ff <= 3'h0;
            div_ff <= 8'h00;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
        end
        else
        begin
            div_ff <= (state_ff == SDM_IDLE || half_done) ? 8'h00 : div_ff + 8'h01;
            case (state_ff)
                SDM_IDLE:
                begin
                    if (start)
                    begin
                        tx_ff <= wdata_i;
                        bit_ff <= SDM_CNT_LAST;
                        cs_n_ff <= 1'b0;
                        state_ff <= SDM_LOW;
                    end
                end
                SDM_LOW:   // clock low, data stable: raise clock
                begin
                    if (half_done)
                    begin
                        sclk_ff <= 1'b1;
                        rx_ff <= {rx_ff[6:0], dout_s};
                        state_ff <= SDM_HIGH;
                    end
                end
                SDM_HIGH:  // clock high: fall and move to next bit
                begin
                    if (half_done)
                    begin
                        sclk_ff <= 1'b0;
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        bit_ff <= bit_ff - 3'h1;
                        state_ff <= (bit_ff == 3'h0) ? SDM_DONE : SDM_LOW;
                    end
                end
                SDM_DONE:  // raise select: device latches
                begin
                    if (half_done)
                    begin
                        cs_n_ff <= 1'b1;
                        state_ff <= SDM_IDLE;
                    end
                end
                default: state_ff <= SDM_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // register port: read data one cycle later
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_ctl_ff <= 1'b0;
            dev_rst_n_ff <= 1'b0;  // device held cleared until we run
            rdata_ff <= 8'h00;
        end
        else
        begin
            rst_ctl_ff <= nxt_rst_ctl;
            dev_rst_n_ff <= ~nxt_rst_ctl;
            case (addr_i)
                SDM_REG_TXWORD: rdata_ff <= rd_i ? tx_ff : 8'h00;
                SDM_REG_STATUS: rdata_ff <= rd_i ? {7'h00, state_ff != SDM_IDLE} : 8'h00;
                SDM_REG_RXWORD: rdata_ff <= rd_i ? rx_ff : 8'h00;
                SDM_REG_CTRL: rdata_ff <= rd_i ? {7'h00, rst_ctl_ff} : 8'h00;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign rdata_o = rdata_ff;
    assign link.sclk = sclk_ff;
    assign link.cs_n = cs_n_ff;
    assign link.din = tx_ff[7];          // msb first
    assign link.reset_n = dev_rst_n_ff;
endmodule

/* tb/sdm_properties.sv */
module sdm_properties
#(
    parameter int DIV = 4
)
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic reset_n,
    input wire logic [3:0] group_a_input_o,
    input wire logic [3:0] group_b_input_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sclk_q_ff;  // link clock one cycle late
    logic [7:0] word_ff;  // mirror of the device register
    logic [7:0] hi_ff;  // cycles the link clock stood high
    wire logic rise = sclk && !sclk_q_ff;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // ----------------------------------------
    // helpers: mirror is lost by a controller reset mid run
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sclk_q_ff <= 1'b0;
            word_ff <= 8'h00;
            hi_ff <= 8'h00;
        end
        else
        begin
            sclk_q_ff <= sclk;
            hi_ff <= sclk ? hi_ff + 8'h01 : 8'h00;
            if (!reset_n)
                word_ff <= 8'h00;
            else if (rise && !cs_n)
                word_ff <= {word_ff[6:0], din};
        end
    end
    AST_RESET_OPEN:
    assert property (!reset_n |-> {group_a_input_o, group_b_input_o} == 8'h00)
        else $error("switch closed in device reset");
    AST_LATCH_B:
    assert property ($rose(cs_n) && reset_n |->
        group_b_input_o == {word_ff[4], word_ff[5], word_ff[6], word_ff[7]})
        else $error("group b latch wrong");
    AST_LATCH_A:
    assert property ($rose(cs_n) && reset_n |-> group_a_input_o == word_ff[3:0])
        else $error("group a latch wrong");
    AST_HOLD_SHIFT:
    assert property (!cs_n && reset_n |=>
        cs_n || !reset_n || $stable({group_a_input_o, group_b_input_o}))
        else $error("switches moved while shifting");
    AST_DOUT_LAG:
    assert property (rise && !cs_n |-> dout == word_ff[7])
        else $error("dout not eight bits late");
    AST_DOUT_HOLD:
    assert property (cs_n && $past(cs_n) && reset_n && $past(reset_n) |-> $stable(dout))
        else $error("dout moved while deselected");
    AST_DIN_STEADY:
    assert property (rise |-> $stable(din))
        else $error("din moved at link clock rise");
    AST_SCLK_HIGH:
    assert property ($fell(sclk) |-> hi_ff == 8'(DIV))
        else $error("link clock high time wrong");
    AST_IDLE_CLOCK:
    assert property (cs_n |-> !sclk)
        else $error("link clock runs outside frame");
    cover property ($rose(cs_n) && group_b_input_o == 4'hF);
    cover property ($rose(cs_n) && group_a_input_o == 4'h1);
    cover property ($fell(reset_n));
endmodule

/* tb/tb_serial_dual_mux_switch_control.sv */
module tb_serial_dual_mux_switch_control;
    import sdm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;  // write strobe to the controller
    logic rd_s = 1'b0;  // read strobe to the controller
    logic [7:0] rdata;
    logic [3:0] ga;
    logic [3:0] gb;
    logic [7:0] rx;  // last value read
    int err_count = 0;
    int num_checks = 0;
    sdm_link_if link();
    always #2 clock_i = ~clock_i;
    sdm_ctrl #(.DIV(SDM_SCLK_DIV)) sdm_ctrl_inst (.clock_i(clock_i), .nrst_i(nrst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .link(link));
    sdm_device sdm_device_inst (.link(link), .group_a_input_o(ga), .group_b_input_o(gb));
    sdm_properties #(.DIV(SDM_SCLK_DIV)) sdm_properties_inst (.clock_i(clock_i),
        .nrst_i(nrst_i), .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din),
        .dout(link.dout), .reset_n(link.reset_n), .group_a_input_o(ga),
        .group_b_input_o(gb));
    task automatic finish_test();
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one cycle strobes; read data taken in the cycle after
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock_i);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock_i);
        rd_s <= 1'b0;
        #1 rx = rdata;
    endtask
    // bounded poll of busy
    task automatic wait_idle();
        int n;
        rd(SDM_REG_STATUS);
        for (n = 0; n < 100 && rx[0] !== 1'b0; n++)
            rd(SDM_REG_STATUS);
        if (n == 100)
        begin
            err_count++;
            finish_test();
        end
    endtask
    task automatic send(input logic [7:0] w);
        wr(SDM_REG_TXWORD, w);
        wait_idle();
    endtask
    task automatic chk_sw(input logic [7:0] w);
        chk("group_b", {4'h0, gb}, {4'h0, w[4], w[5], w[6], w[7]});
        chk("group_a", {4'h0, ga}, {4'h0, w[3:0]});
    endtask
    localparam logic [7:0] SDM_TAB [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
        8'h02, 8'h01, 8'hFF, 8'h00, 8'hA5};
    // walking one plus full and empty words
    task automatic t_map();
        logic [7:0] prev;
        prev = 8'h00;
        chk_sw(8'h00);
        foreach (SDM_TAB[i])
        begin
            send(SDM_TAB[i]);
            chk_sw(SDM_TAB[i]);
            rd(SDM_REG_RXWORD);
            chk("rxword", rx, prev);
            prev = SDM_TAB[i];
        end
    endtask
    // second start while busy is dropped; old state held mid frame
    task automatic t_busy();
        wr(SDM_REG_TXWORD, 8'hC3);
        wr(SDM_REG_TXWORD, 8'h5A);
        wr(4'h6, 8'hFF);
        repeat (20) @(posedge clock_i);
        chk_sw(8'hA5);
        wait_idle();
        chk_sw(8'hC3);
    endtask
    // device reset acts at once and blocks shifting
    task automatic t_devrst();
        wr(SDM_REG_CTRL, 8'h01);
        #1 chk_sw(8'h00);
        send(8'h81);
        chk_sw(8'h00);
        wr(SDM_REG_CTRL, 8'h00);
        send(8'h18);
        chk_sw(8'h18);
        rd(SDM_REG_RXWORD);
        chk("rxword", rx, 8'h00);
    endtask
    initial
    begin
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_map();
        t_busy();
        t_devrst();
        finish_test();
    end
endmodule
